// [dv/mcm_host.sv]
/*
  Host model for the serial register link of the metering front end.
  Assumes one frame at a time, called from the bench; 80 ns link clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mcm_host (
  // Link pins toward the device
  output logic      SCLK,
  output logic      CS_N,
  output logic      DIN,
  input  wire logic DOUT,
  input  wire logic DOUT_OE
);
  initial begin
    SCLK = 1'b0;
    DIN  = 1'b0;
    // Late first rise so the link clear is never missed
    #1 CS_N = 1'b1;
  end

  task automatic xfer(input logic [7:0] c, input logic [15:0] w,
                      output logic [15:0] r);
    logic [23:0] sh;
    int          n;
    n = (c[5:0] == 6'h09) ? 16 : 8;
    sh = {c & 8'hbf, (n == 16) ? w : {w[7:0], 8'h00}};
    r = 16'h0000;
    CS_N = 1'b0;
    #150;
    for (int i = 0; i < 8 + n; i++) begin
      if (i == 8 && !c[7])
        #400;
      DIN = sh[23-i];
      #40 SCLK = 1'b1;
      #40 r = {r[14:0], (i >= 8) ? DOUT : 1'b0};
      SCLK = 1'b0;
    end
    #120 CS_N = 1'b1;
    // Released line shows the inverse
    DIN = ~DIN;
    #200;
  endtask
endmodule
`default_nettype wire

// [dv/mcm_regs_chk.sv]
/*
  Concurrent checks on the ports of the configuration front end.
  Assumes it is bound into mcm_regs; one system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module mcm_chk (
  // Clocking
  input wire logic                      SYS_CLK,
  input wire logic                      RSTN,
  input wire logic                      CE,
  // Link
  input wire logic                      SCLK,
  input wire logic                      CS_N,
  input wire logic                      DIN,
  input wire logic                      DOUT,
  input wire logic                      DOUT_OE,
  // Core side
  input wire mcm_pkg::mcm_cfg_s         CONFIG,
  input wire logic [mcm_pkg::DIV_W-1:0] SAMPLE_DIVIDE,
  input wire logic                      CH1_FROM_VOLTAGE_PAIR,
  input wire logic                      THERMAL_START,
  input wire logic                      THERMAL_DONE,
  input wire logic                      SOFT_RESET
);
  default clocking cb @(posedge SYS_CLK); endclocking
  logic [8:0] hi_cnt;

  // Counts enabled cycles of soft reset
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN || !SOFT_RESET)
      hi_cnt <= 9'h000;
    else if (CE)
      hi_cnt <= hi_cnt + 9'h001;
  end

  property p_rst;
    !RSTN |=> CONFIG == 16'h000c && SAMPLE_DIVIDE == 11'h080
              && !SOFT_RESET && !THERMAL_START;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_div;
    disable iff (!RSTN) $stable(CONFIG.sample_rate_select) ##1
      $stable(CONFIG.sample_rate_select)
      |-> SAMPLE_DIVIDE == (11'h080 << CONFIG.sample_rate_select);
  endproperty
  a_div: assert property (p_div) else $error("divide wrong");
  property p_swap;
    disable iff (!RSTN) $stable(CONFIG.channel_swap) ##1
      $stable(CONFIG.channel_swap)
      |-> CH1_FROM_VOLTAGE_PAIR == CONFIG.channel_swap;
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_sr0;
    disable iff (!RSTN) CONFIG.soft_chip_reset == 1'b0;
  endproperty
  a_sr0: assert property (p_sr0) else $error("reset bit kept");
  property p_src;
    disable iff (!RSTN) CONFIG.sample_source_select != 2'h1;
  endproperty
  a_src: assert property (p_src) else $error("reserved source");
  property p_srlen;
    disable iff (!RSTN) $fell(SOFT_RESET) |-> hi_cnt == 9'h168;
  endproperty
  a_srlen: assert property (p_srlen) else $error("soft len");
  property p_srcfg;
    disable iff (!RSTN) $rose(SOFT_RESET) |-> ##[0:2] CONFIG == 16'h000c;
  endproperty
  a_srcfg: assert property (p_srcfg) else $error("soft cfg");
  property p_tst;
    disable iff (!RSTN) $rose(CONFIG.thermal_conversion_start)
      |-> THERMAL_START ##1 !THERMAL_START;
  endproperty
  a_tst: assert property (p_tst) else $error("thermal start");
  property p_tdone;
    disable iff (!RSTN) CE && THERMAL_DONE && !THERMAL_START
      |=> !CONFIG.thermal_conversion_start || THERMAL_START;
  endproperty
  a_tdone: assert property (p_tdone) else $error("thermal clear");
  property p_oe;
    disable iff (!RSTN) CS_N |-> !DOUT_OE && !DOUT;
  endproperty
  a_oe: assert property (p_oe) else $error("drive off frame");

  c_srst: cover property ($rose(SOFT_RESET));
  c_tst: cover property (THERMAL_START);
  c_oe: cover property (DOUT_OE);
  c_rate: cover property (CONFIG.sample_rate_select == 2'h3);
endmodule

bind mcm_regs mcm_chk chk (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE), .SCLK(SCLK), .CS_N(CS_N),
  .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .CONFIG(CONFIG),
  .SAMPLE_DIVIDE(SAMPLE_DIVIDE),
  .CH1_FROM_VOLTAGE_PAIR(CH1_FROM_VOLTAGE_PAIR),
  .THERMAL_START(THERMAL_START), .THERMAL_DONE(THERMAL_DONE),
  .SOFT_RESET(SOFT_RESET)
);
`default_nettype wire

// [dv/tb_meter_command_and_mode_regs.sv]
/*
  Self-checking bench for the command front end and configuration word.
  Assumes the host model and checker; 20 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  error_cnt++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_meter_command_and_mode_regs;
  logic              sys_clk;
  logic              rstn;
  logic              ce;
  logic              t_done;
  logic              sclk;
  logic              cs_n;
  logic              din;
  logic              dout;
  logic              dout_oe;
  mcm_pkg::mcm_cfg_s cfg;
  logic [10:0]       div;
  logic              ch1v;
  logic              t_start;
  logic              srst;
  logic [15:0]       exp_cfg;
  logic [15:0]       v;
  logic [15:0]       rd;
  logic [5:0]        a;
  int                n;
  int                error_cnt = 0;
  int                checks_done = 0;
  int                seed = 13675;
  logic [15:0]       corner [6] = '{16'h2000, 16'hffbf, 16'h8004,
                                    16'h0800, 16'h1800, 16'h1000};

  mcm_host host (.SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
                 .DOUT_OE(dout_oe));
  mcm_regs uut (.SYS_CLK(sys_clk), .RSTN(rstn), .CE(ce), .SCLK(sclk),
                .CS_N(cs_n), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe),
                .CONFIG(cfg), .SAMPLE_DIVIDE(div),
                .CH1_FROM_VOLTAGE_PAIR(ch1v), .THERMAL_START(t_start),
                .THERMAL_DONE(t_done), .SOFT_RESET(srst));

  function automatic logic [15:0] cfg_after(input logic [15:0] old,
                                            input logic [15:0] w);
    cfg_after = w & 16'hffbf;
    if (w[14:13] == 2'h1)
      cfg_after[14:13] = old[14:13];
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask

  task automatic cmp_cfg;
    host.xfer(8'h09, 16'h0000, rd);
    `CHK(rd, exp_cfg)
    `CHK(cfg, exp_cfg)
    `CHK(div, 11'h080 << exp_cfg[12:11])
    `CHK(ch1v, exp_cfg[10])
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    #3000000;
    error_cnt++;
    results;
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    t_done = 1'b0;
    exp_cfg = 16'h000c;
    repeat (3) @(posedge sys_clk);
    #2 rstn = 1'b1;
    tick(3);
    cmp_cfg;
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      v = (i < 6) ? corner[i] : 16'($random(seed));
      v[6] = 1'b0;
      host.xfer(8'h89, v, rd);
      tick(6);
      exp_cfg = cfg_after(exp_cfg, v);
      cmp_cfg;
      if (exp_cfg[5]) begin
        t_done = 1'b1;
        tick(1);
        t_done = 1'b0;
        tick(2);
        exp_cfg[5] = 1'b0;
        `CHK(cfg.thermal_conversion_start, 1'b0)
      end
    end
    $display("test writes done");
    a = 6'($random(seed));
    if (a == 6'h09)
      a = 6'h0a;
    host.xfer({2'h2, a}, 16'hffff, rd);
    tick(6);
    cmp_cfg;
    host.xfer({2'h0, a}, 16'h0000, rd);
    `CHK(rd, 16'h0000)
    $display("test other address done");
    host.xfer(8'h89, 16'h8041, rd);
    tick(6);
    exp_cfg = 16'h000c;
    `CHK(cfg, exp_cfg)
    `CHK(srst, 1'b1)
    // Low enable freezes the soft reset
    ce = 1'b0;
    tick(10);
    `CHK(srst, 1'b1)
    `CHK(cfg, exp_cfg)
    ce = 1'b1;
    n = 0;
    // hold off until soft reset ends
    while (srst === 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      results;
    end
    cmp_cfg;
    host.xfer(8'h89, 16'h8000, rd);
    tick(6);
    exp_cfg = 16'h8000;
    cmp_cfg;
    $display("test soft reset done");
    rstn = 1'b0;
    tick(3);
    rstn = 1'b1;
    tick(3);
    exp_cfg = 16'h000c;
    cmp_cfg;
    $display("test mid-run reset done");
    results;
  end
endmodule
`undef CHK
`default_nettype wire

// [verilog/mcm_link.sv]
/*
  Link-side shifter: collects the command byte and the data phase on the
  host's serial clock, shifts read data out, and raises frame-held levels
  for the system side.
  Assumes the serial clock runs only while the select is low; select high
  clears the frame state. Captured words stay until the next capture.
*/
`timescale 1ns/1ps
`default_nettype none
module mcm_link (
  // Link pins
  input  wire logic                        sclk,
  input  wire logic                        cs_n,
  input  wire logic                        din,
  output logic                             dout,
  output logic                             dout_oe,
  // Toward the system side
  input  wire logic [mcm_pkg::CFG_W-1:0]   rd_word,
  output logic                             cmd_done,
  output logic                             wr_done,
  output mcm_pkg::mcm_cmd_s                cmd,
  output logic      [mcm_pkg::CFG_W-1:0]   wr_word
);

  typedef struct packed {
    logic [mcm_pkg::CNT_W-1:0] cnt;
    logic [mcm_pkg::CFG_W-1:0] sh;
    logic                      dout;
    logic                      oe;
    logic                      cmd_done;
    logic                      wr_done;
  } mcm_link_s;

  mcm_link_s               r;
  mcm_link_s               next_r;
  mcm_pkg::mcm_cmd_s       next_cmd;
  logic [mcm_pkg::CFG_W-1:0] next_wr_word;
  logic [mcm_pkg::CNT_W-1:0] last;

  always_comb begin
    next_r       = r;
    next_cmd     = cmd;
    next_wr_word = wr_word;
    last = mcm_pkg::CNT_W'(mcm_pkg::CMD_W)
         + mcm_pkg::data_bits(cmd.target_register_select);
    if (r.cnt < mcm_pkg::CNT_W'(mcm_pkg::CMD_W)) begin
      next_r.sh  = {r.sh[mcm_pkg::CFG_W-2:0], din};
      next_r.cnt = r.cnt + 1'b1;
      if (r.cnt == mcm_pkg::CNT_W'(mcm_pkg::CMD_W - 1)) begin
        next_cmd        = mcm_pkg::mcm_cmd_s'(
                            {r.sh[mcm_pkg::CMD_W-2:0], din});
        next_r.cmd_done = 1'b1;
      end
    end else if (r.cnt < last) begin
      next_r.cnt = r.cnt + 1'b1;
      if (cmd.write) begin
        next_r.sh = {r.sh[mcm_pkg::CFG_W-2:0], din};
        if (r.cnt == last - 1'b1) begin
          next_wr_word   = {r.sh[mcm_pkg::CFG_W-2:0], din};
          next_r.wr_done = 1'b1;
        end
      end else if (r.cnt == mcm_pkg::CNT_W'(mcm_pkg::CMD_W)) begin
        // Left-align the read word, present its MSB
        next_r.sh = (cmd.target_register_select == mcm_pkg::CFG_ADDR)
                  ? rd_word
                  : {rd_word[mcm_pkg::SHORT_W-1:0],
                     mcm_pkg::SHORT_W'(0)};
        next_r.dout = next_r.sh[mcm_pkg::CFG_W-1];
        next_r.oe   = 1'b1;
      end else begin
        next_r.sh   = {r.sh[mcm_pkg::CFG_W-2:0], 1'b0};
        next_r.dout = r.sh[mcm_pkg::CFG_W-2];
      end
    end else begin
      next_r.oe = 1'b0;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Held words carry no reset so the system side can still take them
  always_ff @(posedge sclk) begin
    cmd     <= next_cmd;
    wr_word <= next_wr_word;
  end

  assign dout     = r.dout;
  assign dout_oe  = r.oe;
  assign cmd_done = r.cmd_done;
  assign wr_done  = r.wr_done;

endmodule
`default_nettype wire

// [verilog/mcm_pkg.sv]
/*
  Shared constants and carriers for the meter command and configuration
  front end: register address, command byte layout, configuration word
  layout with its reset value, and timing figures.
  Assumes a 20 MHz system clock; the link clock is supplied by the host.
*/
package mcm_pkg;

  localparam int unsigned CMD_W       = 8;
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned CFG_W       = 16;
  localparam int unsigned SHORT_W     = 8;
  localparam int unsigned CNT_W       = 6;
  localparam int unsigned DIV_W       = 11;
  localparam int unsigned BUSY_W      = 9;

  localparam int unsigned CMD_WRITE_BIT = 7;
  localparam int unsigned CMD_SPARE_BIT = 6;
  localparam int unsigned CMD_ADDR_MSB  = 5;

  localparam logic [ADDR_W-1:0] CFG_ADDR = 6'h09;

  localparam int unsigned SYS_CLK_HZ    = 20_000_000;
  localparam int unsigned SOFT_RESET_US = 18;
  localparam int unsigned SOFT_RESET_CYCLES =
    (SOFT_RESET_US * (SYS_CLK_HZ / 1_000) + 999) / 1_000;
  localparam int unsigned CMD_GAP_NS     = 400;
  localparam int unsigned FRAME_GUARD_NS = 150;

  localparam logic [DIV_W-1:0] RATE_BASE_DIV = 11'h080;
  localparam logic [1:0]       SRC_RESERVED  = 2'h1;

  typedef struct packed {
    logic       positive_only_accumulate;
    logic [1:0] sample_source_select;
    logic [1:0] sample_rate_select;
    logic       channel_swap;
    logic       ch2_inputs_short;
    logic       ch1_inputs_short;
    logic       half_cycle_accumulate;
    logic       soft_chip_reset;
    logic       thermal_conversion_start;
    logic       converters_power_down;
    logic       dip_detect_off;
    logic       pulse_output_off;
    logic       product_lowpass_bypass;
    logic       highpass_bypass;
  } mcm_cfg_s;

  localparam logic [CFG_W-1:0] CFG_RESET = 16'h000c;

  typedef struct packed {
    logic                write;
    logic                spare;
    logic [ADDR_W-1:0]   target_register_select;
  } mcm_cmd_s;

  // Length of the data phase that follows a command byte
  function automatic logic [CNT_W-1:0] data_bits(
    input logic [ADDR_W-1:0] addr);
    data_bits = (addr == CFG_ADDR) ? CNT_W'(CFG_W) : CNT_W'(SHORT_W);
  endfunction

endpackage

// [verilog/mcm_regs.sv]
/*
  Command front end and operating configuration register of a metering
  device. A host reaches the register over a serial link; the link side
  runs on the host's clock and hands frame-held levels across.
  Assumes the host leaves the documented gaps around each frame and after
  a soft reset, and that the thermal unit pulses its done input once.
*/
`timescale 1ns/1ps
`default_nettype none
module mcm_regs (
  // System clock and control
  input  wire logic                            SYS_CLK,
  input  wire logic                            RSTN,
  input  wire logic                            CE,
  // Serial link
  input  wire logic                            SCLK,
  input  wire logic                            CS_N,
  input  wire logic                            DIN,
  output logic                                 DOUT,
  output logic                                 DOUT_OE,
  // Configuration to the metering core
  output mcm_pkg::mcm_cfg_s                    CONFIG,
  output logic      [mcm_pkg::DIV_W-1:0]       SAMPLE_DIVIDE,
  output logic                                 CH1_FROM_VOLTAGE_PAIR,
  // Thermal conversion handshake
  output logic                                 THERMAL_START,
  input  wire logic                            THERMAL_DONE,
  // Chip-wide soft reset
  output logic                                 SOFT_RESET
);

  typedef struct packed {
    mcm_pkg::mcm_cfg_s                cfg;
    logic [mcm_pkg::ADDR_W-1:0]       addr;
    logic                             is_write;
    logic [mcm_pkg::CFG_W-1:0]        rd_word;
    logic [1:0]                       seen;
    logic [mcm_pkg::BUSY_W-1:0]       busy;
    logic                             soft_reset;
    logic                             therm_start;
    logic [mcm_pkg::DIV_W-1:0]        divide;
  } mcm_sys_s;

  localparam mcm_sys_s SYS_RESET = '{
    cfg:         mcm_pkg::mcm_cfg_s'(mcm_pkg::CFG_RESET),
    addr:        '0,
    is_write:    1'b0,
    rd_word:     '0,
    seen:        '0,
    busy:        '0,
    soft_reset:  1'b0,
    therm_start: 1'b0,
    divide:      mcm_pkg::RATE_BASE_DIV
  };

  // Waveform update divider from the rate code
  function automatic logic [mcm_pkg::DIV_W-1:0] rate_divide(
    input logic [1:0] code);
    rate_divide = mcm_pkg::RATE_BASE_DIV << code;
  endfunction

  // Value returned by a read of the selected register
  function automatic logic [mcm_pkg::CFG_W-1:0] read_value(
    input logic [mcm_pkg::ADDR_W-1:0] addr,
    input mcm_pkg::mcm_cfg_s          cfg);
    if (addr == mcm_pkg::CFG_ADDR) begin
      read_value = mcm_pkg::CFG_W'(cfg);
    end else begin
      read_value = '0;
    end
  endfunction

  mcm_sys_s                      r;
  mcm_sys_s                      next_r;
  mcm_pkg::mcm_cmd_s             link_cmd;
  logic [mcm_pkg::CFG_W-1:0]     link_wr_word;
  logic                          link_cmd_done;
  logic                          link_wr_done;
  logic [1:0]                    synced;
  logic                          cmd_rise;
  logic                          wr_rise;
  mcm_pkg::mcm_cfg_s             wr_cfg;

  mcm_link u_link (
    .sclk     (SCLK),
    .cs_n     (CS_N),
    .din      (DIN),
    .dout     (DOUT),
    .dout_oe  (DOUT_OE),
    .rd_word  (r.rd_word),
    .cmd_done (link_cmd_done),
    .wr_done  (link_wr_done),
    .cmd      (link_cmd),
    .wr_word  (link_wr_word)
  );

  mcm_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk      (SYS_CLK),
    .rst_n    (RSTN),
    .ce       (CE),
    .async_in ({link_wr_done, link_cmd_done}),
    .sync_out (synced)
  );

  always_comb begin
    next_r             = r;
    next_r.therm_start = 1'b0;
    next_r.seen        = synced;
    cmd_rise = synced[0] & ~r.seen[0];
    wr_rise  = synced[1] & ~r.seen[1];
    wr_cfg   = mcm_pkg::mcm_cfg_s'(link_wr_word);

    if (THERMAL_DONE) begin
      next_r.cfg.thermal_conversion_start = 1'b0;
    end

    if (r.busy != '0) begin
      next_r.busy = r.busy - 1'b1;
    end

    // Transfers are ignored while the soft reset runs
    if (cmd_rise && r.busy == '0) begin
      next_r.addr     = link_cmd.target_register_select;
      next_r.is_write = link_cmd.write;
      next_r.rd_word  = read_value(link_cmd.target_register_select,
                                   r.cfg);
    end

    if (wr_rise && r.busy == '0 && r.is_write &&
        r.addr == mcm_pkg::CFG_ADDR) begin
      if (wr_cfg.soft_chip_reset) begin
        next_r.cfg  = mcm_pkg::mcm_cfg_s'(mcm_pkg::CFG_RESET);
        next_r.busy = mcm_pkg::BUSY_W'(mcm_pkg::SOFT_RESET_CYCLES);
      end else begin
        next_r.cfg.highpass_bypass        = wr_cfg.highpass_bypass;
        next_r.cfg.product_lowpass_bypass = wr_cfg.product_lowpass_bypass;
        next_r.cfg.pulse_output_off       = wr_cfg.pulse_output_off;
        next_r.cfg.dip_detect_off         = wr_cfg.dip_detect_off;
        next_r.cfg.converters_power_down  = wr_cfg.converters_power_down;
        next_r.cfg.half_cycle_accumulate  = wr_cfg.half_cycle_accumulate;
        next_r.cfg.ch1_inputs_short       = wr_cfg.ch1_inputs_short;
        next_r.cfg.ch2_inputs_short       = wr_cfg.ch2_inputs_short;
        next_r.cfg.channel_swap           = wr_cfg.channel_swap;
        next_r.cfg.sample_rate_select     = wr_cfg.sample_rate_select;
        if (wr_cfg.sample_source_select != mcm_pkg::SRC_RESERVED) begin
          next_r.cfg.sample_source_select = wr_cfg.sample_source_select;
        end
        next_r.cfg.positive_only_accumulate =
          wr_cfg.positive_only_accumulate;
        if (wr_cfg.thermal_conversion_start) begin
          next_r.cfg.thermal_conversion_start = 1'b1;
          next_r.therm_start = ~r.cfg.thermal_conversion_start;
        end
      end
    end

    next_r.soft_reset = (next_r.busy != '0);
    next_r.divide     = rate_divide(next_r.cfg.sample_rate_select);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      r <= SYS_RESET;
    end else if (CE) begin
      r <= next_r;
    end
  end

  assign CONFIG                = r.cfg;
  assign SAMPLE_DIVIDE         = r.divide;
  assign CH1_FROM_VOLTAGE_PAIR = r.cfg.channel_swap;
  assign THERMAL_START         = r.therm_start;
  assign SOFT_RESET            = r.soft_reset;

endmodule
`default_nettype wire

// [verilog/mcm_sync.sv]
/*
  Two-flop level synchroniser into the system clock domain.
  Assumes inputs are levels that hold for at least two system cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module mcm_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clocking
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } mcm_sync_s;

  mcm_sync_s r;
  mcm_sync_s next_r;

  always_comb begin
    next_r.meta   = async_in;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign sync_out = r.stable;

endmodule
`default_nettype wire
